// ==== design/lwt_pkg.sv ====
// package: register map, control layouts and constants of the lifetime and wake-up timers
package lwt_pkg;
   localparam logic [31:0] LT_LOAD_ADDR = 32'hffff0300;
   localparam logic [31:0] LT_LOW_ADDR = 32'hffff0304;
   localparam logic [31:0] LT_HIGH_ADDR = 32'hffff0308;
   localparam logic [31:0] LT_CTRL_ADDR = 32'hffff030c;
   localparam logic [31:0] LT_CLR_ADDR = 32'hffff0310;
   localparam logic [31:0] LT_CAP_ADDR = 32'hffff0314;
   localparam logic [31:0] WK_LOAD_ADDR = 32'hffff0340;
   localparam logic [31:0] WK_CNT_ADDR = 32'hffff0344;
   localparam logic [31:0] WK_CTRL_ADDR = 32'hffff0348;
   localparam logic [31:0] WK_CLR_ADDR = 32'hffff034c;

   // clock select code that means the core clock, per timer
   localparam logic [1:0] LT_CORE_SEL = 2'h3;
   localparam logic [1:0] WK_CORE_SEL = 2'h1;

   localparam int PRESC_W = 15;
   localparam int EVT_N = 18;
   localparam logic [4:0] EVT_LAST = 5'h11;
   localparam logic [4:0] EVT_LT = 5'h00;
   localparam logic [4:0] EVT_WK = 5'h02;

   localparam logic [15:0] NARROW_MAX = 16'hffff;
   localparam logic [47:0] WIDE_MAX = 48'hffff_ffff_ffff;
   localparam logic [31:0] WORD_MAX = 32'hffff_ffff;

   // time-of-day limits and the mask of live bits
   localparam logic [6:0] TICK_MAX = 7'h7f;
   localparam logic [5:0] SEC_MAX = 6'h3b;
   localparam logic [5:0] MIN_MAX = 6'h3b;
   localparam logic [7:0] HR_MAX_DAY = 8'h17;
   localparam logic [7:0] HR_MAX_FULL = 8'hff;
   localparam logic [31:0] TOD_MASK = 32'hff3f3f7f;

   typedef enum logic [1:0] {
      FMT_BIN = 2'b00,
      FMT_RSVD = 2'b01,
      FMT_TOD23 = 2'b10,
      FMT_TOD255 = 2'b11
   } lwt_fmt_t;

   typedef struct packed {
      logic [13:0] rsvd_hi;
      logic cap_en;
      logic [4:0] evt_sel;
      logic rsvd_b11;
      logic [1:0] clk_sel;
      logic up;
      logic en;
      logic periodic;
      logic rsvd_b5;
      logic wide;
      logic [3:0] presc;
   } lwt_lt_ctrl_t;

   typedef struct packed {
      logic [20:0] rsvd_hi;
      logic [1:0] clk_sel;
      logic up;
      logic en;
      logic periodic;
      lwt_fmt_t fmt;
      logic [3:0] presc;
   } lwt_wk_ctrl_t;
endpackage : lwt_pkg

// ==== design/lwt_tick.sv ====
// source select, pin synchronisers and power-of-two prescaler for one timer
module lwt_tick #(
   parameter logic [1:0] CORE_SEL = 2'h3,
   parameter int PW = 15
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [3:0] src_pin,
   input wire logic core_on,
   input wire logic [1:0] sel,
   input wire logic [3:0] presc,
   input wire logic restart,
   output logic tick
);
   logic [3:0] s1_q, s2_q, s3_q;
   logic [PW-1:0] div_q;
   logic [PW-1:0] mask;
   logic lvl;

   // two stages before anything reads a pin, a third only for edge detection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= 4'h0;
         s2_q <= 4'h0;
         s3_q <= 4'h0;
      end else begin
         s1_q <= src_pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // the core clock source counts every cycle it runs, others count rising edges
   assign lvl = (sel == CORE_SEL) ? core_on : (s2_q[sel] & ~s3_q[sel]);
   assign mask = PW'((32'h1 << presc) - 32'h1);
   assign tick = lvl && ((div_q & mask) == mask);

   // divider restarts on a control or clear write so the first period is whole
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= '0;
      end else if (restart) begin
         div_q <= '0;
      end else if (lvl) begin
         div_q <= div_q + PW'(1);
      end
   end
endmodule // lwt_tick

// ==== design/lwt_timers.sv ====
// lifetime and wake-up timers behind an apb slave
module lwt_timers (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic osc32k_pin,
   input wire logic xtal32k_pin,
   input wire logic undivided_pll_clock,
   input wire logic core_clk_on,
   input wire logic [17:0] event_src,
   output logic lifetime_irq,
   output logic wakeup_irq
);
   lwt_pkg::lwt_lt_ctrl_t lt_ctrl_q, lt_wr_c;
   lwt_pkg::lwt_wk_ctrl_t wk_ctrl_q, wk_wr_c;
   logic [15:0] lt_load_q, lt_cap_q;
   logic [47:0] lt_cnt_q;
   logic [31:0] wk_load_q, wk_cnt_q;
   logic [31:0] prdata_q, rd_d;
   logic pready_q, pslverr_q, lt_irq_q, wk_irq_q, evt_q;
   logic wr_en, wr_lt_ctrl, wr_lt_clr, wr_wk_ctrl, wr_wk_clr;
   logic lt_tick, wk_tick, lt_run, wk_run, lt_term, wk_term, wk_tod;
   logic evt_lvl, cap_fire;
   logic [7:0] wk_hmax;
   logic [31:0] wk_max;
   localparam int EVT_N_W = lwt_pkg::EVT_N;
   logic [EVT_N_W-1:0] src_vec;

   // time-of-day step: each field carries into the next one
   function automatic logic [31:0] tod_step(input logic [31:0] v, input logic up,
                                            input logic [7:0] hmax);
      logic [7:0] h;
      logic [5:0] m;
      logic [5:0] s;
      logic [6:0] t;
      h = v[31:24];
      m = v[21:16];
      s = v[13:8];
      t = v[6:0];
      if (up) begin
         if (t != lwt_pkg::TICK_MAX) begin
            t = t + 7'h01;
         end else begin
            t = 7'h00;
            if (s != lwt_pkg::SEC_MAX) begin
               s = s + 6'h01;
            end else begin
               s = 6'h00;
               if (m != lwt_pkg::MIN_MAX) begin
                  m = m + 6'h01;
               end else begin
                  m = 6'h00;
                  h = (h >= hmax) ? 8'h00 : h + 8'h01;
               end
            end
         end
      end else begin
         if (t != 7'h00) begin
            t = t - 7'h01;
         end else begin
            t = lwt_pkg::TICK_MAX;
            if (s != 6'h00) begin
               s = s - 6'h01;
            end else begin
               s = lwt_pkg::SEC_MAX;
               if (m != 6'h00) begin
                  m = m - 6'h01;
               end else begin
                  m = lwt_pkg::MIN_MAX;
                  h = (h == 8'h00) ? hmax : h - 8'h01;
               end
            end
         end
      end
      return {h, 2'h0, m, 2'h0, s, 1'h0, t};
   endfunction

   // reserved control bits are dropped on write and read as zero
   function automatic lwt_pkg::lwt_lt_ctrl_t lt_clean(input logic [31:0] w);
      lwt_pkg::lwt_lt_ctrl_t c;
      c = lwt_pkg::lwt_lt_ctrl_t'(w);
      c.rsvd_hi = '0;
      c.rsvd_b11 = 1'b0;
      c.rsvd_b5 = 1'b0;
      return c;
   endfunction

   // first value after a start, an overflow or a clear write
   function automatic logic [47:0] lt_first(input lwt_pkg::lwt_lt_ctrl_t c,
                                            input logic [15:0] load);
      if (c.wide) begin
         return 48'h0;
      end else if (c.periodic) begin
         return {32'h0, load};
      end else if (c.up) begin
         return 48'h0;
      end else begin
         return {32'h0, lwt_pkg::NARROW_MAX};
      end
   endfunction

   function automatic logic [31:0] wk_first(input lwt_pkg::lwt_wk_ctrl_t c,
                                            input logic [31:0] load, input logic [31:0] max);
      if (c.periodic) begin
         return c.fmt[1] ? (load & lwt_pkg::TOD_MASK) : load;
      end else begin
         return c.up ? 32'h0 : max;
      end
   endfunction

   function automatic logic reg_hit(input logic [31:0] a);
      return (a == lwt_pkg::LT_LOAD_ADDR) || (a == lwt_pkg::LT_LOW_ADDR) ||
             (a == lwt_pkg::LT_HIGH_ADDR) || (a == lwt_pkg::LT_CTRL_ADDR) ||
             (a == lwt_pkg::LT_CLR_ADDR) || (a == lwt_pkg::LT_CAP_ADDR) ||
             (a == lwt_pkg::WK_LOAD_ADDR) || (a == lwt_pkg::WK_CNT_ADDR) ||
             (a == lwt_pkg::WK_CTRL_ADDR) || (a == lwt_pkg::WK_CLR_ADDR);
   endfunction

   // apb: zero-wait answer, a write lands at the edge that ends the access phase
   assign wr_en = psel && penable && pwrite && pready_q;
   assign wr_lt_ctrl = wr_en && (paddr == lwt_pkg::LT_CTRL_ADDR);
   assign wr_lt_clr = wr_en && (paddr == lwt_pkg::LT_CLR_ADDR);
   assign wr_wk_ctrl = wr_en && (paddr == lwt_pkg::WK_CTRL_ADDR);
   assign wr_wk_clr = wr_en && (paddr == lwt_pkg::WK_CLR_ADDR);
   assign lt_wr_c = lt_clean(pwdata);
   assign wk_wr_c = lwt_pkg::lwt_wk_ctrl_t'({21'h0, pwdata[10:0]});

   // read data is sampled in the setup cycle, so a live count is one cycle old
   always_comb begin
      rd_d = 32'h0;
      if (paddr == lwt_pkg::LT_LOAD_ADDR) begin
         rd_d = {16'h0, lt_load_q};
      end else if (paddr == lwt_pkg::LT_LOW_ADDR) begin
         rd_d = {16'h0, lt_cnt_q[15:0]};
      end else if (paddr == lwt_pkg::LT_HIGH_ADDR) begin
         rd_d = lt_cnt_q[47:16];
      end else if (paddr == lwt_pkg::LT_CTRL_ADDR) begin
         rd_d = lt_ctrl_q;
      end else if (paddr == lwt_pkg::LT_CAP_ADDR) begin
         rd_d = {16'h0, lt_cap_q};
      end else if (paddr == lwt_pkg::WK_LOAD_ADDR) begin
         rd_d = wk_tod ? (wk_load_q & lwt_pkg::TOD_MASK) : wk_load_q;
      end else if (paddr == lwt_pkg::WK_CNT_ADDR) begin
         rd_d = wk_cnt_q;
      end else if (paddr == lwt_pkg::WK_CTRL_ADDR) begin
         rd_d = wk_ctrl_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0;
      end else begin
         pready_q <= psel && !penable;
         pslverr_q <= psel && !penable && !reg_hit(paddr);
         prdata_q <= (psel && !penable && !pwrite) ? rd_d : 32'h0;
      end
   end

   // software registers; the clear registers keep no value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lt_ctrl_q <= '0;
         lt_load_q <= 16'h0;
         wk_ctrl_q <= '0;
         wk_load_q <= 32'h0;
      end else begin
         if (wr_lt_ctrl) lt_ctrl_q <= lt_wr_c;
         if (wr_en && paddr == lwt_pkg::LT_LOAD_ADDR) lt_load_q <= pwdata[15:0];
         if (wr_wk_ctrl) wk_ctrl_q <= wk_wr_c;
         if (wr_en && paddr == lwt_pkg::WK_LOAD_ADDR) wk_load_q <= pwdata;
      end
   end

   // tick sources; the core-clock choice of each timer sits at a different code
   lwt_tick #(.CORE_SEL(lwt_pkg::LT_CORE_SEL), .PW(lwt_pkg::PRESC_W)) u_lt_tick (
      .pclk(pclk),
      .presetn(presetn),
      .src_pin({1'b0, xtal32k_pin, undivided_pll_clock, osc32k_pin}),
      .core_on(core_clk_on),
      .sel(lt_ctrl_q.clk_sel),
      .presc(lt_ctrl_q.presc),
      .restart(wr_lt_ctrl || wr_lt_clr),
      .tick(lt_tick)
   );

   // core_clk_on only gates the core-clock choice, the 32 kHz choices keep running
   lwt_tick #(.CORE_SEL(lwt_pkg::WK_CORE_SEL), .PW(lwt_pkg::PRESC_W)) u_wk_tick (
      .pclk(pclk),
      .presetn(presetn),
      .src_pin({undivided_pll_clock, xtal32k_pin, 1'b0, osc32k_pin}),
      .core_on(core_clk_on),
      .sel(wk_ctrl_q.clk_sel),
      .presc(wk_ctrl_q.presc),
      .restart(wr_wk_ctrl || wr_wk_clr),
      .tick(wk_tick)
   );

   // lifetime terminal: full scale in 48-bit, else zero or full scale by direction
   assign lt_run = lt_ctrl_q.en && lt_tick;
   always_comb begin
      if (lt_ctrl_q.wide) begin
         lt_term = (lt_cnt_q == lwt_pkg::WIDE_MAX);
      end else if (lt_ctrl_q.up) begin
         lt_term = (lt_cnt_q[15:0] == lwt_pkg::NARROW_MAX);
      end else begin
         lt_term = (lt_cnt_q[15:0] == 16'h0);
      end
   end

   // lifetime counter: a control or clear write restarts it at once, a terminal tick reloads
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lt_cnt_q <= 48'h0;
      end else if (wr_lt_ctrl) begin
         lt_cnt_q <= lt_first(lt_wr_c, lt_load_q);
      end else if (wr_lt_clr) begin
         lt_cnt_q <= lt_first(lt_ctrl_q, lt_load_q);
      end else if (lt_run) begin
         if (lt_term) begin
            lt_cnt_q <= lt_first(lt_ctrl_q, lt_load_q);
         end else if (lt_ctrl_q.wide) begin
            lt_cnt_q <= lt_cnt_q + 48'h1;
         end else if (lt_ctrl_q.up) begin
            lt_cnt_q <= {32'h0, lt_cnt_q[15:0] + 16'h1};
         end else begin
            lt_cnt_q <= {32'h0, lt_cnt_q[15:0] - 16'h1};
         end
      end
   end

   // a terminal tick in the same cycle as a clear write keeps the flag set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lt_irq_q <= 1'b0;
      end else if (lt_run && lt_term) begin
         lt_irq_q <= 1'b1;
      end else if (wr_lt_clr) begin
         lt_irq_q <= 1'b0;
      end
   end

   // event source vector; the timers feed their own codes
   always_comb begin
      src_vec = event_src;
      src_vec[lwt_pkg::EVT_LT] = event_src[lwt_pkg::EVT_LT] | lt_irq_q;
      src_vec[lwt_pkg::EVT_WK] = event_src[lwt_pkg::EVT_WK] | wk_irq_q;
   end
   // codes beyond the last event select nothing
   assign evt_lvl = (lt_ctrl_q.evt_sel <= lwt_pkg::EVT_LAST) && src_vec[lt_ctrl_q.evt_sel];
   assign cap_fire = lt_ctrl_q.cap_en && !lt_ctrl_q.wide && evt_lvl && !evt_q;

   // capture on the rising edge only; the counter is not disturbed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt_q <= 1'b0;
         lt_cap_q <= 16'h0;
      end else begin
         evt_q <= evt_lvl;
         if (cap_fire) lt_cap_q <= lt_cnt_q[15:0];
      end
   end

   // wake-up limits follow the selected format
   assign wk_tod = wk_ctrl_q.fmt[1];
   assign wk_hmax = (wk_ctrl_q.fmt == lwt_pkg::FMT_TOD23) ? lwt_pkg::HR_MAX_DAY
                                                          : lwt_pkg::HR_MAX_FULL;
   assign wk_max = wk_tod ? {wk_hmax, 2'h0, lwt_pkg::MIN_MAX, 2'h0, lwt_pkg::SEC_MAX, 1'h0,
                             lwt_pkg::TICK_MAX} : lwt_pkg::WORD_MAX;
   assign wk_run = wk_ctrl_q.en && wk_tick;
   assign wk_term = wk_ctrl_q.up ? (wk_cnt_q == wk_max) : (wk_cnt_q == 32'h0);

   // wake-up counter: same restart rules as the lifetime timer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wk_cnt_q <= 32'h0;
      end else if (wr_wk_ctrl) begin
         wk_cnt_q <= wk_first(wk_wr_c, wk_load_q,
                              wk_wr_c.fmt[1] ? {(wk_wr_c.fmt == lwt_pkg::FMT_TOD23) ?
                              lwt_pkg::HR_MAX_DAY : lwt_pkg::HR_MAX_FULL, 2'h0,
                              lwt_pkg::MIN_MAX, 2'h0, lwt_pkg::SEC_MAX, 1'h0,
                              lwt_pkg::TICK_MAX} : lwt_pkg::WORD_MAX);
      end else if (wr_wk_clr) begin
         wk_cnt_q <= wk_first(wk_ctrl_q, wk_load_q, wk_max);
      end else if (wk_run) begin
         if (wk_term) begin
            wk_cnt_q <= wk_first(wk_ctrl_q, wk_load_q, wk_max);
         end else if (wk_tod) begin
            wk_cnt_q <= tod_step(wk_cnt_q, wk_ctrl_q.up, wk_hmax);
         end else if (wk_ctrl_q.up) begin
            wk_cnt_q <= wk_cnt_q + 32'h1;
         end else begin
            wk_cnt_q <= wk_cnt_q - 32'h1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wk_irq_q <= 1'b0;
      end else if (wk_run && wk_term) begin
         wk_irq_q <= 1'b1;
      end else if (wr_wk_clr) begin
         wk_irq_q <= 1'b0;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign lifetime_irq = lt_irq_q;
   assign wakeup_irq = wk_irq_q;

   // checks on the counters, flags and apb answer
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_lt_clear;
      wr_lt_clr && !(lt_run && lt_term);
   endsequence
   sequence s_idle2;
      (!lt_ctrl_q.en && !wr_en) [*2];
   endsequence

   a_clear_drops_irq: assert property (s_lt_clear |=> !lifetime_irq)
      else $error("lifetime irq survived a clear write");
   a_term_sets_irq: assert property (lt_run && lt_term && !wr_en |=> lifetime_irq)
      else $error("terminal count did not raise irq");
   a_start_from_load: assert property (wr_lt_ctrl && lt_wr_c.periodic && !lt_wr_c.wide
                                       |=> lt_cnt_q[15:0] == $past(lt_load_q))
      else $error("periodic start did not use load value");
   a_free_restart: assert property (lt_run && lt_term && !wr_en && !lt_ctrl_q.wide &&
                                    !lt_ctrl_q.periodic && !lt_ctrl_q.up
                                    |=> lt_cnt_q[15:0] == lwt_pkg::NARROW_MAX)
      else $error("free-running down count did not restart at maximum");
   a_narrow_high: assert property (!lt_ctrl_q.wide |-> lt_cnt_q[47:16] == 32'h0)
      else $error("upper count bits live in 16-bit mode");
   a_capture_copy: assert property (cap_fire |=> lt_cap_q == $past(lt_cnt_q[15:0]))
      else $error("capture did not copy count");
   a_disabled_hold: assert property (s_idle2 |-> $stable(lt_cnt_q))
      else $error("disabled lifetime timer moved");
   a_wake_reload: assert property (wr_wk_clr && wk_ctrl_q.periodic && !wk_tod
                                   |=> wk_cnt_q == $past(wk_load_q))
      else $error("wake-up clear did not reload");
   a_tod_gaps: assert property (wk_tod |-> (wk_cnt_q & ~lwt_pkg::TOD_MASK) == 32'h0)
      else $error("time-of-day gap bits set");
   a_wake_down: assert property (wk_run && !wk_term && !wk_ctrl_q.up && !wk_tod && !wr_en
                                 |=> wk_cnt_q == $past(wk_cnt_q) - 32'h1)
      else $error("wake-up binary down step wrong");
   a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("apb answer not in first access cycle");
endmodule // lwt_timers

// ==== dv/lwt_timers_bench.sv ====
// self-checking bench for the lifetime and wake-up timers behind apb
module lwt_timers_bench;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic rd;
      logic err;
      logic [31:0] data;
   } lwt_note_t;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, core_clk_on;
   logic lifetime_irq, wakeup_irq;
   logic [31:0] paddr, pwdata, prdata, ld;
   logic [2:0] pin_q;
   logic [17:0] event_src;
   lwt_note_t note_q[$];
   lwt_note_t note;
   int bad_count, check_count, cyc, n, c;
   // wake-up select code for osc, pll, xtal, core in that order
   localparam logic [31:0] WK_SEL [4] = '{32'h0, 32'h3, 32'h2, 32'h1};
   localparam logic [31:0] RD_ADDR [8] = '{lwt_pkg::LT_LOAD_ADDR, lwt_pkg::LT_LOW_ADDR,
      lwt_pkg::LT_HIGH_ADDR, lwt_pkg::LT_CTRL_ADDR, lwt_pkg::LT_CAP_ADDR,
      lwt_pkg::WK_LOAD_ADDR, lwt_pkg::WK_CNT_ADDR, lwt_pkg::WK_CTRL_ADDR};

   lwt_timers u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .osc32k_pin(pin_q[0]), .xtal32k_pin(pin_q[2]),
      .undivided_pll_clock(pin_q[1]), .core_clk_on(core_clk_on), .event_src(event_src),
      .lifetime_irq(lifetime_irq), .wakeup_irq(wakeup_irq));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t word %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_flag(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
      end
   endtask

   // one apb transfer; the note is queued before the request is raised
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
         input logic [31:0] exp, input logic err);
      note_q.push_back('{rd: ~w, err: err, data: exp});
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no local limit: only the hang guard may end this wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      // an idle edge keeps two transfers from driving psel in one time step
      @(posedge pclk);
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 32'h0, 1'b0);
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] exp);
      apb(1'b0, a, $urandom, exp, 1'b0);
   endtask

   // source events: pins pulse slowly for the synchronisers, core source is gated
   task automatic ticks(input int kind, input int cnt);
      if (kind == 3) begin
         core_clk_on <= 1'b1;
         repeat (cnt) @(posedge pclk);
         core_clk_on <= 1'b0;
      end else begin
         repeat (cnt) begin
            pin_q[kind] <= 1'b1;
            repeat (4) @(posedge pclk);
            pin_q[kind] <= 1'b0;
            repeat (4) @(posedge pclk);
         end
      end
      repeat (8) @(posedge pclk);
   endtask

   // answer watcher: each completed transfer retires the oldest note
   always @(posedge pclk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
         if (note_q.size() == 0) begin
            check_flag(1'b1, 1'b0);
         end else begin
            note = note_q.pop_front();
            check_flag(pslverr, note.err);
            if (note.rd) begin
               check_word(prdata, note.data);
            end
         end
      end
      // the answer must not show up before the access phase
      if (psel === 1'b1 && penable === 1'b0) begin
         check_flag(pready, 1'b0);
      end
   end

   // hang guard, far above the expected run length
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         bad_count++;
         stop_test();
      end
   end

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
      pin_q = 3'h0;
      core_clk_on = 1'b0;
      event_src = 18'h0;
      cyc = 0;
      void'($urandom(39));
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      foreach (RD_ADDR[i]) rd(RD_ADDR[i], 32'h0);
      wr(lwt_pkg::LT_LOW_ADDR, $urandom);
      rd(lwt_pkg::LT_LOW_ADDR, 32'h0);
      wr(lwt_pkg::WK_CNT_ADDR, $urandom);
      rd(lwt_pkg::WK_CNT_ADDR, 32'h0);
      apb(1'b1, 32'hffff0320, $urandom, 32'h0, 1'b1);
      // every clock source of both timers, counting up
      for (int k = 0; k < 4; k++) begin
         n = 1 + $urandom % 5;
         wr(lwt_pkg::LT_CTRL_ADDR, 32'h180 | 32'(k << 9));
         ticks(k, n);
         rd(lwt_pkg::LT_LOW_ADDR, 32'(n));
         wr(lwt_pkg::WK_CTRL_ADDR, 32'h180 | (WK_SEL[k] << 9));
         ticks(k, n);
         rd(lwt_pkg::WK_CNT_ADDR, 32'(n));
      end
      n = 1 + $urandom % 30;
      wr(lwt_pkg::LT_CTRL_ADDR, 32'h680);
      rd(lwt_pkg::LT_LOW_ADDR, 32'hffff);
      ticks(3, n);
      rd(lwt_pkg::LT_LOW_ADDR, 32'hffff - 32'(n));
      wr(lwt_pkg::LT_CTRL_ADDR, 32'h790);
      ticks(3, n);
      rd(lwt_pkg::LT_LOW_ADDR, 32'(n));
      rd(lwt_pkg::LT_HIGH_ADDR, 32'h0);
      wr(lwt_pkg::LT_CTRL_ADDR, 32'h784);
      ticks(3, 48);
      rd(lwt_pkg::LT_LOW_ADDR, 32'h3);
      // periodic down to zero, interrupt, reload, clear
      ld = 32'h2 + $urandom % 6;
      wr(lwt_pkg::LT_LOAD_ADDR, ld);
      rd(lwt_pkg::LT_LOAD_ADDR, ld);
      wr(lwt_pkg::LT_CTRL_ADDR, 32'h6c0);
      ticks(3, int'(ld));
      rd(lwt_pkg::LT_LOW_ADDR, 32'h0);
      check_flag(lifetime_irq, 1'b0);
      ticks(3, 1);
      check_flag(lifetime_irq, 1'b1);
      rd(lwt_pkg::LT_LOW_ADDR, ld);
      ticks(3, 1);
      wr(lwt_pkg::LT_CLR_ADDR, $urandom);
      rd(lwt_pkg::LT_LOW_ADDR, ld);
      check_flag(lifetime_irq, 1'b0);
      wr(lwt_pkg::LT_LOAD_ADDR, 32'hfffd);
      wr(lwt_pkg::LT_CTRL_ADDR, 32'h7c0);
      ticks(3, 3);
      check_flag(lifetime_irq, 1'b1);
      rd(lwt_pkg::LT_LOW_ADDR, 32'hfffd);
      // capture on the selected event only, counter keeps running
      c = 3 + $urandom % 15;
      wr(lwt_pkg::LT_CTRL_ADDR, 32'h20780 | 32'(c << 12));
      ticks(3, n);
      event_src[c ^ 1] <= 1'b1;
      repeat (8) @(posedge pclk);
      rd(lwt_pkg::LT_CAP_ADDR, 32'h0);
      event_src[c] <= 1'b1;
      repeat (8) @(posedge pclk);
      rd(lwt_pkg::LT_CAP_ADDR, 32'(n));
      event_src <= 18'h0;
      ticks(3, 2);
      rd(lwt_pkg::LT_LOW_ADDR, 32'(n + 2));
      // wake-up time-of-day rollover, hour limits, interrupt and clear
      wr(lwt_pkg::WK_LOAD_ADDR, 32'h003b3b7e);
      wr(lwt_pkg::WK_CTRL_ADDR, 32'h3e0);
      ticks(3, 2);
      rd(lwt_pkg::WK_CNT_ADDR, 32'h01000000);
      wr(lwt_pkg::WK_LOAD_ADDR, 32'h173b3b7f);
      wr(lwt_pkg::WK_CTRL_ADDR, 32'h3e0);
      ticks(3, 1);
      check_flag(wakeup_irq, 1'b1);
      rd(lwt_pkg::WK_CNT_ADDR, 32'h173b3b7f);
      wr(lwt_pkg::WK_CLR_ADDR, $urandom);
      check_flag(wakeup_irq, 1'b0);
      wr(lwt_pkg::WK_CTRL_ADDR, 32'h3f0);
      ticks(3, 1);
      rd(lwt_pkg::WK_CNT_ADDR, 32'h18000000);
      wr(lwt_pkg::WK_CTRL_ADDR, 32'h0a8);
      rd(lwt_pkg::WK_CNT_ADDR, 32'h173b3b7f);
      ticks(0, 256);
      rd(lwt_pkg::WK_CNT_ADDR, 32'h173b3b7e);
      ld = $urandom | 32'h100;
      wr(lwt_pkg::WK_LOAD_ADDR, ld);
      wr(lwt_pkg::WK_CTRL_ADDR, 32'h2c0);
      ticks(3, n);
      rd(lwt_pkg::WK_CNT_ADDR, ld - 32'(n));
      repeat (4) @(posedge pclk);
      stop_test();
   end
endmodule // lwt_timers_bench
